// file: verilog/upsm_pkg.sv
// Purpose: shared constants and types for the power-state manager and its host end
// Assumes: one 200 MHz clock, synchronous active-high reset
// Notes:   times are kept in their own unit; cycle counts derive from the clock rate, except the fixed PHY_RDY_FAST_CYC
package upsm_pkg;

  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned PHY_SOFT_RESET_BIT_MS      = 2;
  localparam int unsigned PHY_RDY_MS      = 100;
  localparam int unsigned PHY_SOFT_RESET_BIT_CYC     = PHY_SOFT_RESET_BIT_MS * (CLK_HZ / 1000);
  localparam int unsigned PHY_RDY_CYC     = PHY_RDY_MS * (CLK_HZ / 1000);
  localparam int unsigned PHY_RDY_FAST_CYC = 16;

  // host register map (byte addresses)
  localparam logic [3:0] HREG_CTRL   = 4'h0;
  localparam logic [3:0] HREG_STATUS = 4'h4;
  localparam logic [3:0] HREG_EVENT  = 4'h8;
  // event register bit positions
  localparam int unsigned EVT_SUSPEND = 0;
  localparam int unsigned EVT_RESUME  = 1;
  // control bit positions
  localparam int unsigned CTL_CONFIG  = 0;
  localparam int unsigned CTL_PHYRST  = 1;
  localparam int unsigned CTL_SKIPREF = 2;
  localparam int unsigned CTL_SUSSEL  = 3;
  localparam int unsigned CTL_USBRST  = 5;
  localparam int unsigned CTL_LDEN    = 6;

  typedef enum logic [1:0] {
    UPSM_SUS01 = 2'h0,
    UPSM_SUS_RSVD = 2'h1,
    UPSM_SUS2  = 2'h2,
    UPSM_SUS3  = 2'h3
  } upsm_sus_t;
  localparam upsm_sus_t SUS_SEL_RST = UPSM_SUS2;

  typedef enum logic [7:0] {
    ST_UNPWR   = 8'h01,
    ST_PLLWAIT = 8'h02,
    ST_UNCFG   = 8'h04,
    ST_CFG     = 8'h08,
    ST_SUS0    = 8'h10,
    ST_SUS2U   = 8'h20,
    ST_SUS2    = 8'h40,
    ST_SUS3    = 8'h80
  } upsm_state_t;

endpackage : upsm_pkg

// file: verilog/upsm_if.sv
// Purpose: link between the power-state manager and the host-side controller
// Assumes: all signals synchronous to MCLK
// Notes:   host drives link events as one-cycle pulses and levels
interface upsm_if (input wire logic mclk);
  logic       set_config;   // level: host has configured device
  logic       link_suspend; // pulse: usb2 suspend or U3 entry
  logic       link_resume;  // pulse: usb2 resume, L0 or U3->U0
  logic       usb_reset;    // pulse
  logic       phy_soft_reset_bit; // pulse
  logic       skip_analog_ref_wait;
  logic [1:0] suspend_select;
  logic       load_enable;
  logic       ready;
  logic       loading;
  logic [7:0] state;
  logic       sus2_from_uncfg_resumed;

  modport dev  (input set_config, link_suspend, link_resume, usb_reset, phy_soft_reset_bit,
                skip_analog_ref_wait, suspend_select, load_enable,
                output ready, loading, state, sus2_from_uncfg_resumed);
  modport host (output set_config, link_suspend, link_resume, usb_reset, phy_soft_reset_bit,
                skip_analog_ref_wait, suspend_select, load_enable,
                input ready, loading, state, sus2_from_uncfg_resumed);
endinterface : upsm_if

// file: verilog/upsm_sync.sv
// Purpose: two-flop level synchroniser
// Assumes: input may be asynchronous to MCLK
// Notes:   first stage feeds only the second
module upsm_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  logic meta_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : upsm_sync

// file: verilog/upsm_dev.sv
// Purpose: power-state manager of a usb-to-ethernet bridge
// Assumes: MCLK derives from the always-running reference; SRST is the system reset
// Notes:   phy readiness is modelled by a timer, not an analog handshake
module upsm_dev #(
  parameter int unsigned PHY_SOFT_RESET_BIT_CYCLES = upsm_pkg::PHY_SOFT_RESET_BIT_CYC,
  parameter int unsigned PHY_RDY_CYCLES = upsm_pkg::PHY_RDY_CYC
) (
  input  wire logic MCLK,
  input  wire logic SRST,
  input  wire logic USB_POWER_DETECT,
  input  wire logic PLL_STABLE,
  input  wire logic RESET_PIN_N,
  input  wire logic WAKE_EVENT,
  input  wire logic LOAD_DONE,
  upsm_if.dev       LNK,
  output logic      CHIP_RESET,
  output logic      OSC_EN,
  output logic      PLL_EN,
  output logic      PHY_RESET,
  output logic      PHY_ENABLE,
  output logic      ALL_CLK_EN,
  output logic      LOAD_START
);

  // a zero hold count would release the phy before its minimum reset time
  if (PHY_SOFT_RESET_BIT_CYCLES < 1) begin : g_bad_rst_cycles
    $error("upsm_dev: PHY_SOFT_RESET_BIT_CYCLES must be at least 1");
  end
  if (PHY_RDY_CYCLES < 1) begin : g_bad_rdy_cycles
    $error("upsm_dev: PHY_RDY_CYCLES must be at least 1");
  end

  // ------------------------------------------------------------
  // input synchronisation
  // ------------------------------------------------------------
  logic pwr_s;
  logic pll_s;
  upsm_sync u_pwr (.clk(MCLK), .rst(SRST), .d(USB_POWER_DETECT), .q(pwr_s));
  upsm_sync u_pll (.clk(MCLK), .rst(SRST), .d(PLL_STABLE),       .q(pll_s));

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  upsm_pkg::upsm_state_t state_reg;
  upsm_pkg::upsm_state_t state_next;
  logic        pwr_prev_reg;
  logic [31:0] phy_cnt_reg;
  logic        phy_hold_reg;  // soft reset timing phase
  logic        phy_wait_reg;  // waiting for phy functional
  logic        ready_reg;
  logic        loading_reg;
  logic        s2u_resumed_reg;

  wire reinit    = LNK.usb_reset | ~RESET_PIN_N;
  wire pwr_rise  = pwr_s & ~pwr_prev_reg;
  wire wake      = LNK.link_resume | WAKE_EVENT;
  wire [31:0] rdy_cycles = LNK.skip_analog_ref_wait ? upsm_pkg::PHY_RDY_FAST_CYC
                                                    : PHY_RDY_CYCLES;
  wire phy_kick  = LNK.phy_soft_reset_bit;
  wire enter_cfg = (state_next == upsm_pkg::ST_CFG) && (state_reg != upsm_pkg::ST_CFG);
  // any restart reloads the full hold, so a repeated kick lengthens it
  wire phy_restart = phy_kick || enter_cfg;
  wire phy_cnt_run = phy_cnt_reg > 32'h1;
  wire next_cfg    = (state_next == upsm_pkg::ST_CFG);
  wire next_unpwr  = (state_next == upsm_pkg::ST_UNPWR);

  always_comb begin
    state_next = state_reg;
    if (!pwr_s) begin
      state_next = upsm_pkg::ST_UNPWR;
    end else begin
      unique case (state_reg)
        upsm_pkg::ST_UNPWR: begin
          if (pwr_s) state_next = upsm_pkg::ST_PLLWAIT;
        end
        upsm_pkg::ST_PLLWAIT: begin
          if (pll_s) state_next = upsm_pkg::ST_UNCFG;
        end
        upsm_pkg::ST_UNCFG: begin
          if (LNK.set_config) state_next = upsm_pkg::ST_CFG;
          else if (LNK.link_suspend) state_next = upsm_pkg::ST_SUS2U;
        end
        upsm_pkg::ST_CFG: begin
          if (!LNK.set_config) state_next = upsm_pkg::ST_UNCFG;
          else if (LNK.link_suspend) begin
            unique case (LNK.suspend_select)
              2'h0:    state_next = upsm_pkg::ST_SUS0;
              2'h3:    state_next = upsm_pkg::ST_SUS3;
              default: state_next = upsm_pkg::ST_SUS2;
            endcase
          end
        end
        upsm_pkg::ST_SUS2U: begin
          if (reinit || wake) state_next = upsm_pkg::ST_UNCFG;
        end
        upsm_pkg::ST_SUS0, upsm_pkg::ST_SUS2, upsm_pkg::ST_SUS3: begin
          if (reinit) state_next = upsm_pkg::ST_UNCFG;
          else if (wake) state_next = upsm_pkg::ST_CFG;
        end
        default: state_next = upsm_pkg::ST_UNPWR;
      endcase
    end
  end

  // ------------------------------------------------------------
  // sequencing registers
  // ------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      // leaves for the pll wait once power is seen through the two-flop synchroniser
      state_reg    <= upsm_pkg::ST_UNPWR;
      pwr_prev_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      pwr_prev_reg <= pwr_s;
    end
  end

  // ------------------------------------------------------------
  // phy reset timer: hold phase, then wait for the phy to work
  // ------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      phy_cnt_reg  <= 32'h0;
      phy_hold_reg <= 1'b0;
      phy_wait_reg <= 1'b0;
    end else if (phy_restart) begin
      phy_cnt_reg  <= PHY_SOFT_RESET_BIT_CYCLES;
      phy_hold_reg <= 1'b1;
      phy_wait_reg <= 1'b0;
    end else if (!next_cfg) begin
      phy_hold_reg <= 1'b0;
      phy_wait_reg <= 1'b0;
      phy_cnt_reg  <= 32'h0;
    end else if (phy_cnt_run) begin
      phy_cnt_reg <= phy_cnt_reg - 32'h1;
    end else if (phy_hold_reg) begin
      phy_hold_reg <= 1'b0;
      phy_wait_reg <= 1'b1;
      phy_cnt_reg  <= rdy_cycles;
    end else begin
      phy_wait_reg <= 1'b0;
      phy_cnt_reg  <= 32'h0;
    end
  end

  // ------------------------------------------------------------
  // ready, config load and pin outputs
  // ------------------------------------------------------------
  wire load_kick      = pwr_rise & LNK.load_enable;
  // software must reprogram the phy after any resume out of the deepest suspend
  wire sus2_wake      = (state_reg == upsm_pkg::ST_SUS2 || state_reg == upsm_pkg::ST_SUS2U)
                        && wake && !reinit && pwr_s;
  // ready waits for the whole phy sequence and any pending config load
  wire ready_next     = next_cfg && !phy_restart && !phy_hold_reg
                        && !phy_wait_reg && !loading_reg;
  wire pll_off_next   = state_next inside {upsm_pkg::ST_UNPWR, upsm_pkg::ST_SUS0,
                                           upsm_pkg::ST_SUS2, upsm_pkg::ST_SUS2U};
  wire phy_off_next   = state_next inside {upsm_pkg::ST_UNPWR, upsm_pkg::ST_SUS2,
                                           upsm_pkg::ST_SUS2U};
  wire phy_reset_next = !next_cfg || phy_restart
                        || (phy_hold_reg && phy_cnt_run);

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ready_reg       <= 1'b0;
      loading_reg     <= 1'b0;
      s2u_resumed_reg <= 1'b0;
      CHIP_RESET      <= 1'b1;
      OSC_EN          <= 1'b0;
      PLL_EN          <= 1'b0;
      PHY_RESET       <= 1'b1;
      PHY_ENABLE      <= 1'b0;
      ALL_CLK_EN      <= 1'b0;
      LOAD_START      <= 1'b0;
    end else begin
      LOAD_START <= load_kick;
      if (load_kick) loading_reg <= 1'b1;
      else if (LOAD_DONE || !pwr_s) loading_reg <= 1'b0;
      ready_reg  <= ready_next;
      // the flag stays until the host resets the phy, set winning a tie
      if (sus2_wake) s2u_resumed_reg <= 1'b1;
      else if (phy_kick) s2u_resumed_reg <= 1'b0;
      CHIP_RESET <= next_unpwr;
      OSC_EN     <= !next_unpwr;
      PLL_EN     <= !pll_off_next;
      PHY_RESET  <= phy_reset_next;
      PHY_ENABLE <= !phy_off_next;
      ALL_CLK_EN <= next_cfg;
    end
  end

  assign LNK.ready   = ready_reg;
  assign LNK.loading = loading_reg;
  assign LNK.state   = state_reg;
  assign LNK.sus2_from_uncfg_resumed = s2u_resumed_reg;

endmodule : upsm_dev

// file: verilog/upsm_host.sv
// Purpose: host-side controller: software registers drive link requests
// Assumes: plain register port, read data one cycle after read strobe
// Notes:   event bits self-clear after one cycle
module upsm_host (
  input  wire logic        MCLK,
  input  wire logic        SRST,
  input  wire logic [3:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [31:0]      RDATA,
  upsm_if.host             LNK
);
  logic       cfg_reg;
  logic       skip_reg;
  logic       lden_reg;
  logic [1:0] sus_reg;
  logic       phyrst_reg;
  logic       usbrst_reg;
  logic       susp_reg;
  logic       resm_reg;

  wire wr_ctl = WR && (ADDR == upsm_pkg::HREG_CTRL);
  wire rd_sts = RD && (ADDR == upsm_pkg::HREG_STATUS);
  wire rd_ctl = RD && (ADDR == upsm_pkg::HREG_CTRL);
  wire wr_evt = WR && (ADDR == upsm_pkg::HREG_EVENT);
  wire [31:0] ctl_val = {24'h0, 1'b0, lden_reg, 1'b0, sus_reg, skip_reg, 1'b0, cfg_reg};
  wire [31:0] sts_val = {20'h0, LNK.state, 1'b0, LNK.sus2_from_uncfg_resumed,
                         LNK.loading, LNK.ready};

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      cfg_reg    <= 1'b0;
      skip_reg   <= 1'b0;
      lden_reg   <= 1'b1;
      sus_reg    <= upsm_pkg::SUS_SEL_RST;
      phyrst_reg <= 1'b0;
      usbrst_reg <= 1'b0;
      susp_reg   <= 1'b0;
      resm_reg   <= 1'b0;
      RDATA      <= 32'h0;
    end else begin
      phyrst_reg <= wr_ctl & WDATA[upsm_pkg::CTL_PHYRST];
      usbrst_reg <= wr_ctl & WDATA[upsm_pkg::CTL_USBRST];
      susp_reg   <= wr_evt & WDATA[upsm_pkg::EVT_SUSPEND];
      resm_reg   <= wr_evt & WDATA[upsm_pkg::EVT_RESUME];
      if (wr_ctl) begin
        cfg_reg  <= WDATA[upsm_pkg::CTL_CONFIG];
        skip_reg <= WDATA[upsm_pkg::CTL_SKIPREF];
        lden_reg <= WDATA[upsm_pkg::CTL_LDEN];
        sus_reg  <= WDATA[upsm_pkg::CTL_SUSSEL +: 2];
      end else if (!cfg_reg) begin
        sus_reg  <= upsm_pkg::SUS_SEL_RST;
      end
      RDATA <= rd_sts ? sts_val : (rd_ctl ? ctl_val : 32'h0);
    end
  end

  assign LNK.set_config           = cfg_reg;
  assign LNK.skip_analog_ref_wait = skip_reg;
  assign LNK.load_enable          = lden_reg;
  assign LNK.suspend_select       = sus_reg;
  assign LNK.phy_soft_reset_bit   = phyrst_reg;
  assign LNK.usb_reset            = usbrst_reg;
  assign LNK.link_suspend         = susp_reg;
  assign LNK.link_resume          = resm_reg;
endmodule : upsm_host

// file: bench/upsm_chk.sv
// Purpose: concurrent checks on the link between the two ends
// Assumes: one clock, synchronous active-high reset
// Notes:   state codes are the package's one-hot values
module upsm_chk (
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic       set_config,
  input wire logic       link_suspend,
  input wire logic       link_resume,
  input wire logic       usb_reset,
  input wire logic       phy_soft_reset_bit,
  input wire logic [1:0] suspend_select,
  input wire logic       ready,
  input wire logic [7:0] state
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  wire logic       is_uncfg = (state == upsm_pkg::ST_UNCFG);
  wire logic       is_cfg   = (state == upsm_pkg::ST_CFG);
  wire logic       is_sus   = (state inside {upsm_pkg::ST_SUS0, upsm_pkg::ST_SUS2U,
                                             upsm_pkg::ST_SUS2, upsm_pkg::ST_SUS3});
  // 01b falls back to the default variant
  wire logic [7:0] sus_exp  = (suspend_select == 2'h0) ? upsm_pkg::ST_SUS0 :
                              (suspend_select == 2'h3) ? upsm_pkg::ST_SUS3 : upsm_pkg::ST_SUS2;
  // ----------------------------------------------------------------
  // state transitions and ready
  // ----------------------------------------------------------------
  property p_ready_normal; ready |-> is_uncfg || is_cfg; endproperty
  a_ready_normal: assert property (p_ready_normal)
    else $error("ready outside normal state");
  property p_sus_entry; is_sus && !$past(is_sus) |-> $past(is_uncfg) || $past(is_cfg); endproperty
  a_sus_entry: assert property (p_sus_entry)
    else $error("suspend entered from a state other than normal");
  property p_sus_uncfg; link_suspend && is_uncfg |-> ##[1:2] state == upsm_pkg::ST_SUS2U; endproperty
  a_sus_uncfg: assert property (p_sus_uncfg)
    else $error("unconfigured suspend did not pick the low-power variant");
  property p_sus_cfg; link_suspend && is_cfg |-> ##[1:2] state == $past(sus_exp); endproperty
  a_sus_cfg: assert property (p_sus_cfg)
    else $error("configured suspend picked the wrong variant");
  property p_no_cfg; state == upsm_pkg::ST_SUS2U |=> !is_cfg; endproperty
  a_no_cfg: assert property (p_no_cfg)
    else $error("configured state reached from unconfigured suspend");
  property p_resume; link_resume && is_sus |-> ##[1:3] is_uncfg || is_cfg; endproperty
  a_resume: assert property (p_resume)
    else $error("resume did not return to normal");
  property p_usbrst; usb_reset && is_sus |-> ##[1:3] is_uncfg; endproperty
  a_usbrst: assert property (p_usbrst)
    else $error("usb reset in suspend did not reach unconfigured");
  property p_config; is_uncfg && set_config && !link_suspend |-> ##[1:2] is_cfg; endproperty
  a_config: assert property (p_config)
    else $error("configuration request ignored");
  property p_deconfig; is_cfg && !set_config |-> ##[1:2] is_uncfg; endproperty
  a_deconfig: assert property (p_deconfig)
    else $error("deconfiguration request ignored");
  property p_phyrst; phy_soft_reset_bit |=> !ready [*8]; endproperty
  a_phyrst: assert property (p_phyrst)
    else $error("ready seen during phy reset");
endmodule : upsm_chk

// file: bench/testbench.sv
// Purpose: self-checking bench joining both ends of the power-state link
// Assumes: short phy timers (20 reset, 50 ready cycles) stand in for the long ones
// Notes:   load requests are answered on the next cycle
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0, srst = 1'b1, pwr_det = 1'b1, pll_ok = 1'b1;
  logic        rst_pin_n = 1'b1, wake = 1'b0, load_done = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr_stb = 1'b0, rd_stb = 1'b0;
  logic [31:0] rdata;
  logic        chip_reset, osc_en, pll_en, phy_reset, phy_enable, all_clk_en, load_start;
  int          err_total = 0, comparisons = 0, n_load = 0;

  upsm_if u_upsm_if (.mclk(mclk));
  upsm_dev #(.PHY_SOFT_RESET_BIT_CYCLES(20), .PHY_RDY_CYCLES(50)) u_upsm_dev (.MCLK(mclk), .SRST(srst),
    .USB_POWER_DETECT(pwr_det), .PLL_STABLE(pll_ok), .RESET_PIN_N(rst_pin_n),
    .WAKE_EVENT(wake), .LOAD_DONE(load_done), .LNK(u_upsm_if.dev), .CHIP_RESET(chip_reset),
    .OSC_EN(osc_en), .PLL_EN(pll_en), .PHY_RESET(phy_reset), .PHY_ENABLE(phy_enable),
    .ALL_CLK_EN(all_clk_en), .LOAD_START(load_start));
  upsm_host u_upsm_host (.MCLK(mclk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr_stb),
    .RD(rd_stb), .RDATA(rdata), .LNK(u_upsm_if.host));
  upsm_chk u_upsm_chk (.mclk(mclk), .srst(srst), .set_config(u_upsm_if.set_config),
    .link_suspend(u_upsm_if.link_suspend), .link_resume(u_upsm_if.link_resume),
    .usb_reset(u_upsm_if.usb_reset), .phy_soft_reset_bit(u_upsm_if.phy_soft_reset_bit),
    .suspend_select(u_upsm_if.suspend_select), .ready(u_upsm_if.ready),
    .state(u_upsm_if.state));

  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    load_done <= load_start;
    if (load_start) n_load <= n_load + 1;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd
  // bounded polls: a hang ends the run with a mismatch
  task automatic wait_st(input logic [7:0] exp);
    int n;
    for (n = 0; n < 400 && u_upsm_if.state !== exp; n++) @(posedge mclk);
    #1 chk(u_upsm_if.state, exp);
    if (n == 400) give_verdict;
  endtask : wait_st
  task automatic wait_ready;
    int n;
    for (n = 0; n < 400 && u_upsm_if.ready !== 1'b1; n++) @(posedge mclk);
    chk(u_upsm_if.ready, 1'b1);
    if (n == 400) give_verdict;
  endtask : wait_ready
  task automatic enter_sus2u;
    bus_wr(upsm_pkg::HREG_EVENT, 32'h1);
    wait_st(upsm_pkg::ST_SUS2U);
  endtask : enter_sus2u
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_power;
    int loads;
    wait_st(upsm_pkg::ST_UNCFG);
    chk(phy_reset, 1'b1);
    @(posedge mclk) pwr_det <= 1'b0;
    wait_st(upsm_pkg::ST_UNPWR);
    chk({chip_reset, osc_en, pll_en, phy_enable}, 4'h8);
    loads = n_load;
    @(posedge mclk) pll_ok <= 1'b0;
    pwr_det <= 1'b1;
    wait_st(upsm_pkg::ST_PLLWAIT);
    chk({osc_en, pll_en}, 2'h3);
    repeat (8) @(posedge mclk);
    chk(u_upsm_if.state, upsm_pkg::ST_PLLWAIT);
    pll_ok <= 1'b1;
    wait_st(upsm_pkg::ST_UNCFG);
    chk(n_load > loads, 1'b1);
    chk({phy_reset, chip_reset}, 2'h2);
    $display("test power done");
  endtask : t_power
  task automatic t_config;
    logic [31:0] d;
    bus_wr(upsm_pkg::HREG_CTRL, 32'h51);
    wait_st(upsm_pkg::ST_CFG);
    // the phy is still held in reset right after configuration
    chk({all_clk_en, phy_reset}, 2'h3);
    wait_ready;
    bus_rd(upsm_pkg::HREG_STATUS, d);
    chk(d[11:0], {upsm_pkg::ST_CFG, 4'h1});
    bus_rd(4'hC, d);
    chk(d, 32'h0);
    $display("test config done");
  endtask : t_config
  task automatic t_phyrst;
    int n;
    bus_wr(upsm_pkg::HREG_CTRL, 32'h57);
    for (n = 0; n < 40 && phy_reset !== 1'b1; n++) @(posedge mclk);
    for (n = 0; n < 400 && phy_reset === 1'b1; n++) @(posedge mclk);
    chk(n >= 20 && n < 400, 1'b1);
    chk({chip_reset, u_upsm_if.ready, u_upsm_if.state}, {2'h0, upsm_pkg::ST_CFG});
    wait_ready;
    $display("test phy reset done");
  endtask : t_phyrst
  task automatic t_suspend;
    logic [7:0] exp_sus [4] = '{upsm_pkg::ST_SUS0, upsm_pkg::ST_SUS2, upsm_pkg::ST_SUS2,
                                upsm_pkg::ST_SUS3};
    // {pll, phy} enables per variant: the deepest one drops both
    logic [1:0] exp_pins [4] = '{2'h1, 2'h0, 2'h0, 2'h3};
    logic [31:0] d;
    for (int i = 0; i < 4; i++) begin
      bus_wr(upsm_pkg::HREG_CTRL, 32'h41 | (i << 3));
      bus_wr(upsm_pkg::HREG_EVENT, 32'h1);
      wait_st(exp_sus[i]);
      chk({pll_en, phy_enable}, exp_pins[i]);
      bus_wr(upsm_pkg::HREG_EVENT, 32'h2);
      wait_st(upsm_pkg::ST_CFG);
      bus_rd(upsm_pkg::HREG_STATUS, d);
      chk(d[2], i > 0);
    end
    bus_wr(upsm_pkg::HREG_CTRL, 32'h43);
    bus_rd(upsm_pkg::HREG_STATUS, d);
    chk(d[2], 1'b0);
    $display("test suspend done");
  endtask : t_suspend
  task automatic t_uncfg;
    logic [31:0] d;
    bus_wr(upsm_pkg::HREG_CTRL, 32'h58);
    wait_st(upsm_pkg::ST_UNCFG);
    bus_rd(upsm_pkg::HREG_CTRL, d);
    chk(d[4:3], 2'h2);
    enter_sus2u;
    bus_wr(upsm_pkg::HREG_EVENT, 32'h2);
    wait_st(upsm_pkg::ST_UNCFG);
    enter_sus2u;
    @(posedge mclk) wake <= 1'b1;
    @(posedge mclk) wake <= 1'b0;
    wait_st(upsm_pkg::ST_UNCFG);
    enter_sus2u;
    bus_wr(upsm_pkg::HREG_CTRL, 32'h78);
    wait_st(upsm_pkg::ST_UNCFG);
    enter_sus2u;
    @(posedge mclk) rst_pin_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_pin_n <= 1'b1;
    wait_st(upsm_pkg::ST_UNCFG);
    $display("test unconfigured suspend done");
  endtask : t_uncfg
  // mid-run system reset with power missing, then power arriving
  task automatic t_reset;
    @(posedge mclk) srst <= 1'b1;
    pwr_det <= 1'b0;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    repeat (8) @(posedge mclk);
    chk({chip_reset, u_upsm_if.state}, {1'b1, upsm_pkg::ST_UNPWR});
    pwr_det <= 1'b1;
    wait_st(upsm_pkg::ST_UNCFG);
    $display("test reset done");
  endtask : t_reset

  initial begin
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    t_power;
    t_config;
    t_phyrst;
    t_suspend;
    t_uncfg;
    t_reset;
    give_verdict;
  end
endmodule : testbench
